// [include/crfs_pkg.sv]
// constants and types shared by the receiver flag and status block
`default_nettype none
package crfs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_RFLG  = 8'h00;
  localparam logic [7:0] OFS_CTRL  = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h08;
  localparam logic [7:0] OFS_ICLR  = 8'h0C;
  localparam logic [7:0] OFS_IEN   = 8'h10;

  // flag register field positions
  localparam int BIT_WAKE  = 7;
  localparam int BIT_CSC   = 6;
  localparam int RX_STATE_FIELD_LSB = 4;
  localparam int TX_STATE_FIELD_LSB = 2;
  localparam int BIT_OVR   = 1;
  localparam int BIT_RXF   = 0;

  // control register field positions
  localparam int CTRL_WDE   = 0;
  localparam int CTRL_INIT  = 1;
  localparam int CTRL_SLEEP = 2;

  // interrupt status, clear and enable bit positions
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_CSC  = 1;
  localparam int IRQ_OVR  = 2;
  localparam int IRQ_RXF  = 3;
  localparam int IRQ_W    = 4;

  // reset values
  localparam logic [7:0]       RFLG_RST = 8'h00;
  localparam logic             WDE_RST  = 1'b0;
  localparam logic [IRQ_W-1:0] IEN_RST  = 4'h0;
  localparam logic [2:0]       SYNC_RST = 3'h7;

  // error counter limits
  localparam logic [8:0] LIM_96  = 9'h060;
  localparam logic [8:0] LIM_127 = 9'h07F;
  localparam logic [8:0] LIM_255 = 9'h0FF;

  // bus state encodings for both state fields
  typedef enum logic [1:0] {
    CRFS_ST_OK      = 2'h0,
    CRFS_ST_WARN    = 2'h1,
    CRFS_ST_PASSIVE = 2'h2,
    CRFS_ST_BUSOFF  = 2'h3
  } crfs_bus_state_t;
endpackage
`default_nettype wire

// [include/crfs_enc_if.sv]
// carrier between the flag logic and the state encoder
`default_nettype none
interface crfs_enc_if;
  logic [8:0]                tx_err_count;
  logic [7:0]                rx_err_count;
  crfs_pkg::crfs_bus_state_t rx_state;
  crfs_pkg::crfs_bus_state_t tx_state;

  modport calc (input tx_err_count, input rx_err_count, output rx_state, output tx_state);
  modport user (output tx_err_count, output rx_err_count, input rx_state, input tx_state);
endinterface
`default_nettype wire

// [hdl/crfs_state_enc.sv]
// maps the error counters onto receiver and transmitter state codes
`default_nettype none
module crfs_state_enc (
  crfs_enc_if.calc enc
);
  // transmitter state from the transmit error counter
  always_comb
  begin
    if (enc.tx_err_count > crfs_pkg::LIM_255)
      enc.tx_state = crfs_pkg::CRFS_ST_BUSOFF;
    else if (enc.tx_err_count > crfs_pkg::LIM_127)
      enc.tx_state = crfs_pkg::CRFS_ST_PASSIVE;
    else if (enc.tx_err_count >= crfs_pkg::LIM_96)
      enc.tx_state = crfs_pkg::CRFS_ST_WARN;
    else
      enc.tx_state = crfs_pkg::CRFS_ST_OK;
  end

  // receiver state, forced to bus-off while the transmitter is off
  always_comb
  begin
    if (enc.tx_err_count > crfs_pkg::LIM_255)
      enc.rx_state = crfs_pkg::CRFS_ST_BUSOFF;
    else if ({1'b0, enc.rx_err_count} > crfs_pkg::LIM_127)
      enc.rx_state = crfs_pkg::CRFS_ST_PASSIVE;
    else if ({1'b0, enc.rx_err_count} > crfs_pkg::LIM_96)
      enc.rx_state = crfs_pkg::CRFS_ST_WARN;
    else
      enc.rx_state = crfs_pkg::CRFS_ST_OK;
  end
endmodule
`default_nettype wire

// [hdl/crfs_top.sv]
// receiver flag and status logic with register port and interrupt
//
// The implementer's own choices: the plain strobed port and the register addresses.
`default_nettype none
module crfs_top (
  input  wire  logic       mclk,
  input  wire  logic       reset_n,
  input  wire  logic [7:0] addr,
  input  wire  logic [7:0] wr_data,
  input  wire  logic       wr_strobe,
  input  wire  logic       rd_strobe,
  output logic       [7:0] rd_data,
  input  wire  logic [8:0] tx_err_count,
  input  wire  logic [7:0] rx_err_count,
  input  wire  logic       init_request,
  input  wire  logic       init_acknowledge,
  input  wire  logic       sleep_mode,
  input  wire  logic       can_rx_pin,
  input  wire  logic       bg_msg_ready,
  input  wire  logic       overrun_event,
  output logic             fg_shift,
  output logic             wake_irq,
  output logic             err_irq,
  output logic             rx_irq,
  output logic             irq
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [2:0]                act_sync;
    logic                      wake_flag;
    logic                      status_change_flag;
    crfs_pkg::crfs_bus_state_t rx_state_field;
    crfs_pkg::crfs_bus_state_t tx_state_field;
    logic                      overrun_flag;
    logic                      rx_full_flag;
    logic                      wake_detect_enable;
    logic [3:0]                irq_status;
    logic [3:0]                irq_enable;
    logic [7:0]                rd_data;
    logic                      fg_shift;
    logic                      wake_irq;
    logic                      err_irq;
    logic                      rx_irq;
    logic                      irq;
  } crfs_state_t;

  localparam crfs_state_t ST_RST = '{
    act_sync:           crfs_pkg::SYNC_RST,
    wake_flag:          1'b0,
    status_change_flag: 1'b0,
    rx_state_field:     crfs_pkg::CRFS_ST_OK,
    tx_state_field:     crfs_pkg::CRFS_ST_OK,
    overrun_flag:       1'b0,
    rx_full_flag:       1'b0,
    wake_detect_enable: crfs_pkg::WDE_RST,
    irq_status:         4'h0,
    irq_enable:         crfs_pkg::IEN_RST,
    rd_data:            8'h00,
    fg_shift:           1'b0,
    wake_irq:           1'b0,
    err_irq:            1'b0,
    rx_irq:             1'b0,
    irq:                1'b0
  };

  crfs_state_t st_ff;
  crfs_state_t nxt_st;

  // ==========================================================
  // state encoder
  crfs_enc_if enc ();

  // counters enter the encoder unchanged
  assign enc.tx_err_count = tx_err_count;
  assign enc.rx_err_count = rx_err_count;

  crfs_state_enc u_enc (
    .enc (enc.calc)
  );

  // ==========================================================
  // decode and events
  logic       in_init;
  logic       bus_active;
  logic       wr_rflg;
  logic       wr_ctrl;
  logic       wr_iclr;
  logic       wr_ien;
  logic       state_diff;
  logic       ev_wake;
  logic       ev_csc;
  logic       ev_ovr;
  logic       ev_shift;
  logic       wake_cause;
  logic [3:0] ev_vec;
  logic [7:0] rflg_view;

  // mode, pin filter and write decode
  always_comb
  begin
    in_init    = init_request & init_acknowledge;
    // change counts once second and third stage agree; dominant is low
    bus_active = (st_ff.act_sync[1] == st_ff.act_sync[2]) & ~st_ff.act_sync[2];
    wr_rflg    = wr_strobe & (addr == crfs_pkg::OFS_RFLG) & ~in_init;
    wr_ctrl    = wr_strobe & (addr == crfs_pkg::OFS_CTRL);
    wr_iclr    = wr_strobe & (addr == crfs_pkg::OFS_ICLR);
    wr_ien     = wr_strobe & (addr == crfs_pkg::OFS_IEN);
  end

  // flag setting events
  always_comb
  begin
    wake_cause = sleep_mode & st_ff.wake_detect_enable & bus_active;
    ev_wake    = wake_cause & ~in_init;
    state_diff = (enc.rx_state != st_ff.rx_state_field)
               | (enc.tx_state != st_ff.tx_state_field);
    ev_csc     = state_diff & ~st_ff.status_change_flag & ~in_init;
    ev_ovr     = overrun_event & ~in_init;
    ev_shift   = bg_msg_ready & ~st_ff.rx_full_flag & ~in_init;
    ev_vec     = 4'h0;
    ev_vec[crfs_pkg::IRQ_WAKE] = ev_wake;
    ev_vec[crfs_pkg::IRQ_CSC]  = ev_csc;
    ev_vec[crfs_pkg::IRQ_OVR]  = ev_ovr;
    ev_vec[crfs_pkg::IRQ_RXF]  = ev_shift;
  end

  // flag register as software reads it
  always_comb
  begin
    rflg_view = crfs_pkg::RFLG_RST;
    rflg_view[crfs_pkg::BIT_WAKE] = st_ff.wake_flag;
    rflg_view[crfs_pkg::BIT_CSC]  = st_ff.status_change_flag;
    rflg_view[crfs_pkg::RX_STATE_FIELD_LSB+1:crfs_pkg::RX_STATE_FIELD_LSB] = st_ff.rx_state_field;
    rflg_view[crfs_pkg::TX_STATE_FIELD_LSB+1:crfs_pkg::TX_STATE_FIELD_LSB] = st_ff.tx_state_field;
    rflg_view[crfs_pkg::BIT_OVR]  = st_ff.overrun_flag;
    rflg_view[crfs_pkg::BIT_RXF]  = st_ff.rx_full_flag;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;

    // three-stage pin synchroniser
    nxt_st.act_sync = {st_ff.act_sync[1:0], can_rx_pin};

    // wake flag; a clear is refused while its cause persists
    if (ev_wake)
      nxt_st.wake_flag = 1'b1;
    else if (wr_rflg & wr_data[crfs_pkg::BIT_WAKE] & ~wake_cause)
      nxt_st.wake_flag = 1'b0;

    // status change flag, set wins over clear
    if (ev_csc)
      nxt_st.status_change_flag = 1'b1;
    else if (wr_rflg & wr_data[crfs_pkg::BIT_CSC])
      nxt_st.status_change_flag = 1'b0;

    // state fields follow the encoder only while no change is pending
    if (~st_ff.status_change_flag)
    begin
      nxt_st.rx_state_field = enc.rx_state;
      nxt_st.tx_state_field = enc.tx_state;
    end

    // overrun flag, set wins over clear
    if (ev_ovr)
      nxt_st.overrun_flag = 1'b1;
    else if (wr_rflg & wr_data[crfs_pkg::BIT_OVR])
      nxt_st.overrun_flag = 1'b0;

    // receive full; clearing releases the foreground buffer
    if (ev_shift)
      nxt_st.rx_full_flag = 1'b1;
    else if (wr_rflg & wr_data[crfs_pkg::BIT_RXF])
      nxt_st.rx_full_flag = 1'b0;
    nxt_st.fg_shift = ev_shift;

    // init mode holds all flags in reset, fields exempt
    if (in_init)
    begin
      nxt_st.wake_flag          = 1'b0;
      nxt_st.status_change_flag = 1'b0;
      nxt_st.overrun_flag       = 1'b0;
      nxt_st.rx_full_flag       = 1'b0;
    end

    // control register
    if (wr_ctrl)
      nxt_st.wake_detect_enable = wr_data[crfs_pkg::CTRL_WDE];

    // sticky interrupt status: set wins over write-one clear
    if (wr_iclr)
      nxt_st.irq_status = st_ff.irq_status & ~wr_data[3:0];
    nxt_st.irq_status = nxt_st.irq_status | ev_vec;
    if (wr_ien)
      nxt_st.irq_enable = wr_data[3:0];

    // pending requests per output, err_irq shared by status change and overrun, enable bits act as masks
    nxt_st.wake_irq = nxt_st.wake_flag
                    & nxt_st.irq_enable[crfs_pkg::IRQ_WAKE];
    nxt_st.err_irq  = (nxt_st.status_change_flag & nxt_st.irq_enable[crfs_pkg::IRQ_CSC])
                    | (nxt_st.overrun_flag & nxt_st.irq_enable[crfs_pkg::IRQ_OVR]);
    nxt_st.rx_irq   = nxt_st.rx_full_flag
                    & nxt_st.irq_enable[crfs_pkg::IRQ_RXF];
    nxt_st.irq      = |(nxt_st.irq_status & nxt_st.irq_enable);

    // read data stand one cycle after the strobe only
    nxt_st.rd_data = 8'h00;
    if (rd_strobe)
    begin
      case (addr)
        crfs_pkg::OFS_RFLG:
        begin
          nxt_st.rd_data = rflg_view;
        end
        crfs_pkg::OFS_CTRL:
        begin
          nxt_st.rd_data[crfs_pkg::CTRL_WDE]   = st_ff.wake_detect_enable;
          nxt_st.rd_data[crfs_pkg::CTRL_INIT]  = in_init;
          nxt_st.rd_data[crfs_pkg::CTRL_SLEEP] = sleep_mode;
        end
        crfs_pkg::OFS_ISTAT:
        begin
          nxt_st.rd_data[3:0] = st_ff.irq_status;
        end
        crfs_pkg::OFS_IEN:
        begin
          nxt_st.rd_data[3:0] = st_ff.irq_enable;
        end
        default:
        begin
          nxt_st.rd_data = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st_ff <= ST_RST;
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign rd_data  = st_ff.rd_data;
  assign fg_shift = st_ff.fg_shift;
  assign wake_irq = st_ff.wake_irq;
  assign err_irq  = st_ff.err_irq;
  assign rx_irq   = st_ff.rx_irq;
  assign irq      = st_ff.irq;

endmodule
`default_nettype wire

// [verification/crfs_top_properties.sv]
// assertions on the ports of the receiver flag and status block
`default_nettype none
module crfs_top_properties (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_strobe,
  input wire logic       rd_strobe,
  input wire logic [7:0] rd_data,
  input wire logic [8:0] tx_err_count,
  input wire logic [7:0] rx_err_count,
  input wire logic       init_request,
  input wire logic       init_acknowledge,
  input wire logic       bg_msg_ready,
  input wire logic       fg_shift,
  input wire logic       wake_irq,
  input wire logic       err_irq,
  input wire logic       rx_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic init_act;
  logic clr_rxf;
  logic rxf_sh_ff;
  logic nxt_rxf_sh;

  assign init_act = init_request && init_acknowledge;
  assign clr_rxf = wr_strobe && addr == crfs_pkg::OFS_RFLG && wr_data[0];

  // shadow of the receive full flag, set a cycle late, cleared in step
  always_comb
  begin
    nxt_rxf_sh = rxf_sh_ff;
    if (fg_shift) nxt_rxf_sh = 1'b1;
    if (clr_rxf || init_act) nxt_rxf_sh = 1'b0;
  end

  // shadow register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n) rxf_sh_ff <= 1'b0;
    else rxf_sh_ff <= nxt_rxf_sh;
  end

  // expected state fields for given counters
  function automatic logic [3:0] enc(input logic [8:0] t, input logic [7:0] r);
    logic [1:0] ts;
    logic [1:0] rs;
    ts = (t > 9'h0FF) ? 2'h3 : (t > 9'h07F) ? 2'h2 : (t >= 9'h060) ? 2'h1 : 2'h0;
    rs = (t > 9'h0FF) ? 2'h3 : (r > 8'h7F) ? 2'h2 : (r > 8'h60) ? 2'h1 : 2'h0;
    return {rs, ts};
  endfunction

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_init_steady;
    (init_act && $stable(tx_err_count) && $stable(rx_err_count))[*3];
  endsequence
  sequence s_flag_read;
    rd_strobe && addr == crfs_pkg::OFS_RFLG;
  endsequence

  a_rd_quiet: assert property (!$past(rd_strobe) |-> rd_data == 8'h00)
    else $error("read data not idle");
  a_state_encode: assert property (s_init_steady ##0 s_flag_read |=>
    rd_data[5:2] == enc($past(tx_err_count), $past(rx_err_count))) else $error("state field code");
  a_init_flags_zero: assert property (s_init_steady ##0 s_flag_read |=> (rd_data & 8'hC3) == 8'h00)
    else $error("flags set in init");
  a_init_irq_quiet: assert property (init_act[*3] |-> !wake_irq && !err_irq && !rx_irq)
    else $error("interrupt in init");
  a_no_double_shift: assert property (fg_shift |-> !rxf_sh_ff)
    else $error("shift while full");
  a_shift_has_cause: assert property (fg_shift |-> $past(bg_msg_ready) && !$past(init_act))
    else $error("shift without message");
  a_shift_taken: assert property (bg_msg_ready && !rxf_sh_ff && !fg_shift && !init_act |=> fg_shift)
    else $error("message not taken");
  a_rx_irq_clear: assert property ((clr_rxf && !bg_msg_ready) ##1 !bg_msg_ready |=> !rx_irq)
    else $error("receive irq stuck");
endmodule

bind crfs_top crfs_top_properties chk_u (.mclk, .reset_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
  .tx_err_count, .rx_err_count, .init_request, .init_acknowledge, .bg_msg_ready, .fg_shift, .wake_irq,
  .err_irq, .rx_irq);
`default_nettype wire

// [verification/crfs_can_node.sv]
// model of the other nodes on the bus feeding the receive path
`default_nettype none
module crfs_can_node #(
  parameter int DEPTH = 1
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic msg_push,
  input  wire logic bus_active,
  input  wire logic fg_shift,
  output logic      can_rx_pin,
  output logic      bg_msg_ready,
  output logic      overrun_event
);
  timeunit 1ns;
  timeprecision 100ps;
  int pending;

  // dominant while a node talks, recessive level otherwise
  assign can_rx_pin = !bus_active;
  assign bg_msg_ready = pending != 0;

  // correct messages waiting behind the foreground buffer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pending <= 0;
      overrun_event <= 1'b0;
    end
    else
    begin
      // a shift in the same cycle frees its slot before the new message lands
      overrun_event <= msg_push && (pending - (fg_shift ? 1 : 0)) >= DEPTH;
      pending <= pending - (fg_shift ? 1 : 0) + ((msg_push && (pending - (fg_shift ? 1 : 0)) < DEPTH) ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

// [verification/crfs_top_test.sv]
// self-checking testbench of the receiver flag and status block
`default_nettype none
module crfs_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, wr_strobe, rd_strobe, init_request, init_acknowledge, sleep_mode;
  logic can_rx_pin, bg_msg_ready, overrun_event, fg_shift, wake_irq, err_irq, rx_irq, irq;
  logic msg_push, bus_active, csc_e;
  logic [7:0] addr, wr_data, rd_data, rx_err_count, d;
  logic [8:0] tx_err_count;
  logic [3:0] cur_e;
  int failures, n_checks, n_shift, seed, i;
  logic [8:0] tx_tab [7] = '{9'h060, 9'h05F, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h000};
  logic [7:0] rx_tab [7] = '{8'h61, 8'h60, 8'h7F, 8'h80, 8'h32, 8'h32, 8'h32};

  crfs_top dut_u (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
    .init_request(init_request), .init_acknowledge(init_acknowledge), .sleep_mode(sleep_mode),
    .can_rx_pin(can_rx_pin), .bg_msg_ready(bg_msg_ready), .overrun_event(overrun_event),
    .fg_shift(fg_shift), .wake_irq(wake_irq), .err_irq(err_irq), .rx_irq(rx_irq), .irq(irq));
  crfs_can_node node_u (.mclk(mclk), .reset_n(reset_n), .msg_push(msg_push), .bus_active(bus_active),
    .fg_shift(fg_shift), .can_rx_pin(can_rx_pin), .bg_msg_ready(bg_msg_ready), .overrun_event(overrun_event));

  // clock and shift counter
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (fg_shift === 1'b1) n_shift++;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wr_data <= v;
    wr_strobe <= 1'b1;
    @(posedge mclk);
    wr_strobe <= 1'b0;
  endtask
  // read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge mclk);
    rd_strobe <= 1'b0;
    @(negedge mclk);
    d = rd_data;
    @(posedge mclk);
  endtask
  task automatic push;
    @(posedge mclk);
    msg_push <= 1'b1;
    @(posedge mclk);
    msg_push <= 1'b0;
  endtask
  function automatic logic [3:0] enc(input logic [8:0] t, input logic [7:0] r);
    logic [1:0] ts;
    logic [1:0] rs;
    ts = (t > 9'h0FF) ? 2'h3 : (t > 9'h07F) ? 2'h2 : (t >= 9'h060) ? 2'h1 : 2'h0;
    rs = (t > 9'h0FF) ? 2'h3 : (r > 8'h7F) ? 2'h2 : (r > 8'h60) ? 2'h1 : 2'h0;
    return {rs, ts};
  endfunction
  // status change expectation after the counters settle
  task automatic settle_chk;
    if (!csc_e && enc(tx_err_count, rx_err_count) != cur_e)
    begin
      cur_e = enc(tx_err_count, rx_err_count);
      csc_e = 1'b1;
    end
    rd(crfs_pkg::OFS_RFLG);
    chk("flags", d, {1'b0, csc_e, cur_e, 2'h0});
    chk("err irq", {7'h00, err_irq}, {7'h00, csc_e});
  endtask

  initial
  begin
    {reset_n, wr_strobe, rd_strobe, init_request, init_acknowledge, sleep_mode, msg_push, bus_active} = '0;
    {addr, wr_data, rx_err_count, tx_err_count, cur_e, csc_e} = '0;
    seed = 57;
    tick(5);
    reset_n <= 1'b1;
    rd(crfs_pkg::OFS_RFLG);
    chk("flags", d, 8'h00);
    rd(8'h14);
    chk("unmapped", d, 8'h00);
    wr(crfs_pkg::OFS_IEN, 8'h0F);
    rd(crfs_pkg::OFS_IEN);
    chk("ien", d, 8'h0F);
    push;
    push;
    tick(4);
    rd(crfs_pkg::OFS_RFLG);
    chk("flags", d, 8'h01);
    chk("rx irq", {7'h00, rx_irq & irq}, 8'h01);
    chk("shifts", 8'(n_shift), 8'h01);
    wr(crfs_pkg::OFS_RFLG, 8'h00);
    rd(crfs_pkg::OFS_RFLG);
    chk("flags", d, 8'h01);
    wr(crfs_pkg::OFS_RFLG, 8'h01);
    tick(3);
    chk("shifts", 8'(n_shift), 8'h02);
    push;
    push;
    tick(2);
    rd(crfs_pkg::OFS_RFLG);
    chk("flags", d, 8'h03);
    wr(crfs_pkg::OFS_RFLG, 8'h03);
    wr(crfs_pkg::OFS_RFLG, 8'h01);
    tick(3);
    chk("rx irq", {7'h00, rx_irq | err_irq}, 8'h00);
    rd(crfs_pkg::OFS_ISTAT);
    chk("istat", d, 8'h0C);
    wr(crfs_pkg::OFS_ICLR, 8'h0F);
    rd(crfs_pkg::OFS_ISTAT);
    chk("istat", d, 8'h00);
    sleep_mode <= 1'b1;
    bus_active <= 1'b1;
    tick(8);
    rd(crfs_pkg::OFS_RFLG);
    chk("no wake", d, 8'h00);
    wr(crfs_pkg::OFS_CTRL, 8'h01);
    for (i = 0; i < 20 && wake_irq !== 1'b1; i++) tick(1);
    chk("wake irq", {7'h00, wake_irq}, 8'h01);
    if (wake_irq !== 1'b1) report_and_stop;
    wr(crfs_pkg::OFS_RFLG, 8'h80);
    rd(crfs_pkg::OFS_RFLG);
    chk("wake kept", d, 8'h80);
    bus_active <= 1'b0;
    tick(5);
    wr(crfs_pkg::OFS_RFLG, 8'h80);
    rd(crfs_pkg::OFS_RFLG);
    chk("wake clear", d, 8'h00);
    sleep_mode <= 1'b0;
    for (i = 0; i < 16; i++)
    begin
      tx_err_count <= (i < 7) ? tx_tab[i] : 9'({$random(seed)} % 320);
      rx_err_count <= (i < 7) ? rx_tab[i] : 8'($random(seed));
      tick(3);
      settle_chk;
      if (i % 2 == 1)
      begin
        wr(crfs_pkg::OFS_RFLG, 8'h40);
        tick(2);
        csc_e = 1'b0;
        settle_chk;
      end
    end
    init_request <= 1'b1;
    init_acknowledge <= 1'b1;
    tx_err_count <= 9'h12C;
    rx_err_count <= 8'h0A;
    push;
    tick(3);
    wr(crfs_pkg::OFS_RFLG, 8'hFF);
    rd(crfs_pkg::OFS_RFLG);
    chk("init flags", d, {2'h0, enc(9'h12C, 8'h0A), 2'h0});
    chk("shifts", 8'(n_shift), 8'h03);
    rd(crfs_pkg::OFS_CTRL);
    chk("control", d, 8'h03);
    init_request <= 1'b0;
    init_acknowledge <= 1'b0;
    tick(3);
    rd(crfs_pkg::OFS_RFLG);
    chk("after init", d, {2'h0, enc(9'h12C, 8'h0A), 2'h1});
    wr(crfs_pkg::OFS_RFLG, 8'h01);
    rd(crfs_pkg::OFS_RFLG);
    chk("rx released", d, {2'h0, enc(9'h12C, 8'h0A), 2'h0});
    chk("rx irq off", {7'h00, rx_irq}, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
